//--- tb/fes_link_chk.sv
// assertions on the link between the host controller and the exception unit
`timescale 1ns/1ps
`default_nettype none
module fes_link_chk
  import fes_pkg::*;
#(
  parameter int BUSY_LEN = BUSY_CYCLES
) (
  input wire logic                core_clk_in,
  input wire logic                rst_n_in,
  input wire logic                esc_valid,
  input wire fes_pkg::fes_op_t    op,
  input wire fes_pkg::fes_cls_t   cls,
  input wire logic                busy,
  input wire logic [SW_WIDTH-1:0] status
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] busy_run;
  wire        take_num = esc_valid && (op != LEGACY_SET_PROTECTED_OP);
  // length of the current busy stretch, checked when it ends
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !busy) busy_run <= 8'h00;
    else busy_run <= busy_run + 8'h01;
  end
  chk_hold_while_busy: assert property (esc_valid |-> !busy)
    else $error("escape offered while busy");
  chk_busy_follows: assert property (take_num |=> $rose(busy))
    else $error("busy did not rise after escape");
  chk_busy_span: assert property ($fell(busy) |-> busy_run == BUSY_LEN)
    else $error("busy stretch has wrong length");
  chk_legacy_inert: assert property (esc_valid && op == LEGACY_SET_PROTECTED_OP |=> !busy && $stable(status))
    else $error("legacy opcode changed state");
  chk_stack_pair: assert property (esc_valid && op == ARITH_OP && cls inside {CLS_STACK_UNDER, CLS_STACK_OVER}
    |=> status[SW_INVALID] && status[SW_STACK])
    else $error("stack fault without both flags");
  chk_ext_load_quiet: assert property (esc_valid && op == STACK_LOAD_EXT_OP && !status[SW_DENORMAL]
    |=> !status[SW_DENORMAL])
    else $error("extended load raised denormal");
  chk_sd_load_denorm: assert property (esc_valid && op == STACK_LOAD_SD_OP && cls == CLS_DENORMAL
    |=> status[SW_DENORMAL])
    else $error("denormal load not flagged");
  chk_sd_load_snan: assert property (esc_valid && op == STACK_LOAD_SD_OP && cls == CLS_SIGNALING_NAN
    |=> status[SW_INVALID])
    else $error("signaling load not invalid");
  chk_quiet_passes: assert property (esc_valid && op == ARITH_OP && cls == CLS_QUIET_NAN && !status[SW_INVALID]
    |=> !status[SW_INVALID])
    else $error("quiet operand raised invalid");
  chk_norm_no_invalid: assert property (esc_valid && op inside {SQUARE_ROOT_OP, DIVIDE_OP, PARTIAL_REMAINDER_OP}
    && cls == CLS_DENORMAL && !status[SW_INVALID] |=> !status[SW_INVALID] && status[SW_DENORMAL])
    else $error("denormal not normalized");
  chk_extract_zero: assert property (esc_valid && op == EXPONENT_SIGNIFICAND_EXTRACT_OP && cls == CLS_ZERO
    |=> status[SW_ZERO_DIV])
    else $error("zero extract without zero divide");
  cov_legacy: cover property (esc_valid && op == LEGACY_SET_PROTECTED_OP);
  cov_stack: cover property (esc_valid && cls == CLS_STACK_OVER);
  cov_busy_end: cover property ($fell(busy));
endmodule
`default_nettype wire

//--- tb/fpu_exception_and_sync_logic_test.sv
// self-checking bench: host controller and exception unit joined by the link
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module fpu_exception_and_sync_logic_test;
  import fes_pkg::*;
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0]  ws = 0;
  logic [5:0]  msk = 6'h3f;
  logic [6:0]  exp_sw = 0;
  wire logic        awr, wrd, bv, arr, rv, irq, rsg, st1, imv, imp, ret;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  wire logic [2:0]  prim;
  wire fes_res_t    kind;
  int err_total = 0, total_checks = 0, n_ret = 0, n_st1 = 0, n_img = 0;
  fes_link_if lnk();
  fes_device u_fes_device (.core_clk_in(clk), .rst_n_in(rst_n), .link(lnk), .result_kind_out(kind),
    .result_sign_out(rsg), .st1_neg_inf_out(st1), .image_valid_out(imv), .image_prot_out(imp),
    .primary_exc_out(prim), .retired_out(ret));
  fes_host u_fes_host (.core_clk_in(clk), .rst_n_in(rst_n), .link(lnk), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .irq_out(irq));
  fes_link_chk u_fes_link_chk (.core_clk_in(clk), .rst_n_in(rst_n), .esc_valid(lnk.esc_valid), .op(lnk.op),
    .cls(lnk.cls), .busy(lnk.busy), .status(lnk.status));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (rst_n) begin
    n_ret += ret;
    n_st1 += st1;
    n_img += imv;
  end
  // flags an operation adds to the sticky status word
  function automatic logic [6:0] mdl(fes_op_t o, fes_cls_t c, logic ov, logic un);
    logic [6:0] f;
    f = 0;
    if (o == LEGACY_SET_PROTECTED_OP) return 0;
    if (c inside {CLS_STACK_UNDER, CLS_STACK_OVER}) f |= 7'h41;
    if (c == CLS_SIGNALING_NAN) f[0] = 1;
    if (c == CLS_QUIET_NAN && o inside {COMPARE_OP, STORE_INTEGER_OP, STORE_PACKED_DECIMAL_POP_OP}) f[0] = 1;
    if (c == CLS_DENORMAL && o != STACK_LOAD_EXT_OP) f[1] = 1;
    if (c == CLS_ZERO && o == EXPONENT_SIGNIFICAND_EXTRACT_OP) f[2] = 1;
    if (ov) f |= 7'h28;
    if (un) f |= 7'h30;
    return f;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a; wd <= d; ws <= 4'hf; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
    end while (!bv);
    r = br; bre <= 0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
    end while (!rv);
    d = rd; r = rr; rre <= 0;
    @(posedge clk);
  endtask
  task automatic rck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rdr(a, d, r);
    `CK(d, e)
  endtask
  // issue one escape and wait out its busy stretch, as the host would
  task automatic run(input fes_op_t o, input fes_cls_t c, input logic s, input logic ov, input logic un);
    int n0;
    logic [1:0] r;
    logic [31:0] d;
    n0 = n_ret;
    wr(REG_CMD, {22'h0, un, ov, s, c, o}, r);
    for (int i = 0; i < 50 && n_ret == n0; i++) @(posedge clk);
    for (int i = 0; i < 50 && lnk.busy; i++) @(posedge clk);
    `CK(n_ret, n0 + 1)
    if (o inside {ENVIRONMENT_LOAD_OP, FULL_STATE_RESTORE_OP}) exp_sw = 0;
    else exp_sw |= mdl(o, c, ov, un);
    rdr(REG_DEV_STAT, d, r);
    `CK(d[9:0], {1'b0, |(exp_sw[5:0] & ~msk), 1'b0, exp_sw})
  endtask
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    wrap_up;
  end
  initial begin
    logic [31:0] d, lim;
    logic [1:0]  r;
    logic [7:0]  tab[$];
    void'($urandom(32'h762e));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rck(REG_CTRL, CTRL_RESET);
    rck(REG_LIMIT, LIMIT_RESET);
    rck(REG_IRQ_STAT, 32'h0);
    rdr(8'h20, d, r);
    `CK(r, 2'h2)
    wr(8'h24, 32'h1, r);
    `CK(r, 2'h2)
    tab = '{{SQUARE_ROOT_OP, CLS_DENORMAL, 1'b1}, {PARTIAL_REMAINDER_OP, CLS_DENORMAL, 1'b1},
      {STORE_PACKED_DECIMAL_POP_OP, CLS_DENORMAL, 1'b1}, {DIVIDE_OP, CLS_DENORMAL, 1'b0},
      {STORE_INTEGER_OP, CLS_DENORMAL, 1'b0}, {TRANSCENDENTAL_OP, CLS_DENORMAL, 1'b0},
      {EXPONENT_SIGNIFICAND_EXTRACT_OP, CLS_DENORMAL, 1'b0}, {STACK_LOAD_EXT_OP, CLS_DENORMAL, 1'b0},
      {EXPONENT_SIGNIFICAND_EXTRACT_OP, CLS_ZERO, 1'b0}, {STACK_LOAD_SD_OP, CLS_DENORMAL, 1'b0},
      {STACK_LOAD_SD_OP, CLS_SIGNALING_NAN, 1'b0}, {ARITH_OP, CLS_SIGNALING_NAN, 1'b0},
      {ARITH_OP, CLS_QUIET_NAN, 1'b0}, {COMPARE_OP, CLS_QUIET_NAN, 1'b0}, {STORE_INTEGER_OP, CLS_QUIET_NAN, 1'b0},
      {STORE_PACKED_DECIMAL_POP_OP, CLS_QUIET_NAN, 1'b0}, {ARITH_OP, CLS_STACK_UNDER, 1'b0},
      {ARITH_OP, CLS_STACK_OVER, 1'b0}};
    foreach (tab[i]) begin
      run(fes_op_t'(tab[i][7:4]), fes_cls_t'(tab[i][3:1]), 1'($urandom), 1'b0, tab[i][0]);
      if (tab[i][7:1] == {ARITH_OP, CLS_SIGNALING_NAN}) `CK(kind, RES_QUIET_NAN)
      if (tab[i][7:1] == {EXPONENT_SIGNIFICAND_EXTRACT_OP, CLS_ZERO}) `CK(n_st1, 1)
      run(ENVIRONMENT_LOAD_OP, CLS_NORMAL, 1'b0, 1'b0, 1'b0);
    end
    for (int k = 0; k < 16; k++) begin
      int rm, s, u;
      logic away;
      rm = k % 4; s = (k / 4) % 2; u = k / 8;
      away = (rm == 2 && s == 0) || (rm == 1 && s == 1);
      wr(REG_CTRL, {24'h0, 6'h3f, 2'(rm)}, r);
      run(ARITH_OP, CLS_NORMAL, s[0], !u[0], u[0]);
      `CK(kind, u ? (away ? RES_MIN_DENORMAL : RES_ZERO) : ((rm == 0 || away) ? RES_INFINITY : RES_MAX_FINITE))
      `CK(prim, u ? 3'h5 : 3'h4)
      `CK(rsg, s[0])
    end
    for (int p = 0; p < 2; p++) begin
      wr(REG_CTRL, {22'h0, 1'(p), 1'b0, 6'h3f, 2'h0}, r);
      run(FULL_STATE_SAVE_OP, CLS_NORMAL, 1'b0, 1'b0, 1'b0);
      `CK(imp, 1'(p))
      run(ENVIRONMENT_STORE_OP, CLS_NORMAL, 1'b0, 1'b0, 1'b0);
      `CK(imp, 1'(p))
    end
    `CK(n_img, 4)
    run(LEGACY_SET_PROTECTED_OP, CLS_SIGNALING_NAN, 1'b0, 1'b0, 1'b0);
    msk = 6'h3e;
    wr(REG_CTRL, {24'h0, 6'h3e, 2'h0}, r);
    wr(REG_IRQ_MASK, 32'h2, r);
    run(ARITH_OP, CLS_SIGNALING_NAN, 1'b0, 1'b0, 1'b0);
    `CK(irq, 1'b1)
    wr(REG_IRQ_STAT, 32'h2, r);
    `CK(irq, 1'b0)
    rck(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_STAT, 32'h1, r);
    run(FULL_STATE_RESTORE_OP, CLS_NORMAL, 1'b0, 1'b0, 1'b0);
    msk = 6'h3f;
    wr(REG_CTRL, CTRL_RESET, r);
    // random limit, operand one past it must fault instead of issuing
    lim = $urandom & 32'h000f_ffff;
    wr(REG_LIMIT, lim, r);
    wr(REG_OPERAND, lim + 32'h1, r);
    wr(REG_IRQ_MASK, 32'h4, r);
    wr(REG_CMD, {28'h0, ARITH_OP}, r);
    for (int i = 0; i < 50 && !irq; i++) @(posedge clk);
    rck(REG_FAULT, {24'h0, VEC_SEGMENT_OVERRUN});
    rck(REG_IRQ_STAT, 32'h5);
    wr(REG_OPERAND, lim, r);
    run(ARITH_OP, CLS_NORMAL, 1'b0, 1'b0, 1'b0);
    wrap_up;
  end
endmodule
`default_nettype wire

//--- verilog/fes_device.sv
// coprocessor exception unit: flags, delivered result kind, busy synchronisation
// Operation
// - masked overflow/underflow rounds per rounding mode
// - normalizing ops take denormals without invalid
// - root, packed store, remainder may underflow
// - transcendental and extract can raise denormal
// - denormal does not outrank every exception
// - zero extract: zero-divide, negative infinity below top when zero-divide is masked
// - stack fault bit marks stack-caused invalid
// - extended load never raises denormal
// - denormal single/double load flags denormal
// - signaling NaN single/double load flags invalid
// - produced NaNs are always quiet
// - signaling NaN traps; quiet only for compare/stores
// - host syncs automatically on numeric ops
// - host waits after environment load or restore
// - legacy set-protected opcode is ignored
// - save image format follows host mode
// - operand past limit gives vector thirteen
// - host holds escapes while coprocessor busy
`timescale 1ns/1ps
`default_nettype none
module fes_device
  import fes_pkg::*;
#(
  parameter int BUSY_LEN = BUSY_CYCLES
) (
  input  wire logic          core_clk_in,
  input  wire logic          rst_n_in,
  fes_link_if.dev            link,
  output fes_pkg::fes_res_t  result_kind_out,
  output logic               result_sign_out,
  output logic               st1_neg_inf_out,
  output logic               image_valid_out,
  output logic               image_prot_out,
  output logic [2:0]         primary_exc_out,
  output logic               retired_out
);
  import fes_pkg::*;

  logic [7:0]          busy_cnt;
  logic [SW_WIDTH-1:0] status;
  fes_res_t            sat_res;

  // ---------------- opcode groups ----------------
  wire fes_op_t op = link.op;
  wire op_env_ld   = (op == ENVIRONMENT_LOAD_OP) || (op == FULL_STATE_RESTORE_OP);
  wire op_img_st   = (op == FULL_STATE_SAVE_OP) || (op == ENVIRONMENT_STORE_OP);
  wire op_legacy   = (op == LEGACY_SET_PROTECTED_OP);
  wire op_load_ext = (op == STACK_LOAD_EXT_OP);
  wire op_extract  = (op == EXPONENT_SIGNIFICAND_EXTRACT_OP);
  // the extended load is a plain move, not a numeric operation
  wire op_numeric  = !op_env_ld && !op_img_st && !op_legacy && !op_load_ext;
  wire op_normalize = (op == SQUARE_ROOT_OP) || (op == DIVIDE_OP) || (op == PARTIAL_REMAINDER_OP)
                   || (op == STORE_INTEGER_OP) || (op == STORE_PACKED_DECIMAL_POP_OP);
  wire op_qnan_traps = (op == COMPARE_OP) || (op == STORE_INTEGER_OP)
                    || (op == STORE_PACKED_DECIMAL_POP_OP);
  wire op_may_unf  = (op == ARITH_OP) || (op == DIVIDE_OP) || (op == TRANSCENDENTAL_OP)
                  || (op == SQUARE_ROOT_OP) || (op == STORE_PACKED_DECIMAL_POP_OP)
                  || (op == PARTIAL_REMAINDER_OP);
  wire op_may_ovf  = (op == ARITH_OP) || (op == DIVIDE_OP) || (op == TRANSCENDENTAL_OP)
                  || (op == STORE_INTEGER_OP) || (op == STORE_PACKED_DECIMAL_POP_OP);

  // ---------------- operand classes ----------------
  wire cls_snan   = (link.cls == CLS_SIGNALING_NAN);
  wire cls_qnan   = (link.cls == CLS_QUIET_NAN);
  wire cls_denorm = (link.cls == CLS_DENORMAL);
  wire cls_zero   = (link.cls == CLS_ZERO);
  wire stack_flt  = (link.cls == CLS_STACK_UNDER) || (link.cls == CLS_STACK_OVER);

  // ---------------- raw exception conditions ----------------
  wire nan_invalid = op_numeric && (cls_snan || (cls_qnan && op_qnan_traps));
  wire exc_ie = stack_flt || nan_invalid;
  // normalizing ops and numeric loads take the denormal and only flag it, never invalid
  wire exc_de = op_numeric && cls_denorm;
  wire exc_ze = cls_zero && (op_extract || (op == DIVIDE_OP));
  wire exc_oe = op_may_ovf && link.res_ovf && !exc_ie;
  wire exc_ue = op_may_unf && link.res_unf && !exc_ie && !exc_ze;
  wire normalized = op_normalize && cls_denorm;

  wire [SW_WIDTH-1:0] new_flags;
  assign new_flags[SW_INVALID]   = exc_ie;
  assign new_flags[SW_DENORMAL]  = exc_de;
  assign new_flags[SW_ZERO_DIV]  = exc_ze;
  assign new_flags[SW_OVERFLOW]  = exc_oe;
  assign new_flags[SW_UNDERFLOW] = exc_ue;
  assign new_flags[SW_PRECISION] = exc_oe || exc_ue;
  assign new_flags[SW_STACK]     = stack_flt;

  // invalid and zero-divide rank above denormal; the old part let denormal win outright
  wire [2:0] primary = exc_ie ? 3'h1 :
                       exc_ze ? 3'h2 :
                       exc_de ? 3'h3 :
                       exc_oe ? 3'h4 :
                       exc_ue ? 3'h5 : 3'h0;

  // ---------------- delivered result ----------------
  wire m_ie = link.mask[SW_INVALID];
  wire m_ze = link.mask[SW_ZERO_DIV];
  wire m_oe = link.mask[SW_OVERFLOW];
  wire m_ue = link.mask[SW_UNDERFLOW];

  fes_sat_round u_sat_round (
    .rnd_in  (link.rnd),
    .sign_in (link.sign),
    .ovf_in  (exc_oe),
    .res_out (sat_res)
  );

  // a signaling input is quieted on the way out, so no signaling NaN is ever produced
  wire fes_res_t next_result =
      !op_numeric                ? RES_NONE :
      exc_ie                     ? (m_ie ? RES_QUIET_NAN : RES_NONE) :
      (exc_ze && op_extract)     ? (m_ze ? RES_NUMBER : RES_NONE) :
      exc_ze                     ? (m_ze ? RES_INFINITY : RES_NONE) :
      exc_oe                     ? (m_oe ? sat_res : RES_NONE) :
      exc_ue                     ? (m_ue ? sat_res : RES_NONE) :
      cls_qnan                   ? RES_QUIET_NAN :
      (op_extract && cls_zero)   ? RES_ZERO :
      normalized                 ? RES_NUMBER :
      RES_NUMBER;

  wire st1_write = op_extract && cls_zero && m_ze;

  // ---------------- acceptance and busy ----------------
  wire accept   = link.esc_valid && (busy_cnt == 8'h00);
  // the legacy opcode is consumed without raising busy or touching any state except the retired_out pulse
  wire do_work  = accept && !op_legacy;

  wire [SW_WIDTH-1:0] next_status = op_env_ld ? SW_RESET : (status | new_flags);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      busy_cnt <= 8'h00;
    end else if (do_work) begin
      busy_cnt <= BUSY_LEN[7:0];
    end else if (busy_cnt != 8'h00) begin
      busy_cnt <= busy_cnt - 8'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      status <= SW_RESET;
    end else if (do_work) begin
      status <= next_status;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      result_kind_out <= RES_NONE;
      result_sign_out <= 1'b0;
      primary_exc_out <= 3'h0;
    end else if (do_work) begin
      result_kind_out <= next_result;
      result_sign_out <= link.sign;
      primary_exc_out <= op_numeric ? primary : 3'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st1_neg_inf_out <= 1'b0;
      image_valid_out <= 1'b0;
      retired_out     <= 1'b0;
    end else begin
      st1_neg_inf_out <= do_work && st1_write;
      image_valid_out <= do_work && op_img_st;
      retired_out     <= accept;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      image_prot_out <= 1'b0;
    end else if (do_work && op_img_st) begin
      image_prot_out <= link.prot_mode;
    end
  end

  // ---------------- link outputs ----------------
  assign link.busy        = (busy_cnt != 8'h00);
  assign link.status      = status;
  assign link.exc_pending = |(status[SW_WIDTH-2:0] & ~link.mask);
endmodule
`default_nettype wire

//--- verilog/fes_host.sv
// host controller: AXI4-Lite registers, escape issue with busy synchronisation
`timescale 1ns/1ps
`default_nettype none
module fes_host
  import fes_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  fes_link_if.host         link,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_out
);
  import fes_pkg::*;

  typedef enum {IDLE, ISSUE, SETTLE, SYNC_WAIT} fes_host_state_t;
  fes_host_state_t state;

  logic        aw_got, w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [31:0] cmd, ctrl, limit, operand;
  logic [2:0]  irq_stat, irq_mask;
  logic [7:0]  fault_vec;
  logic        pending, exc_d;

  // ---------------- write channel ----------------
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  wire aw_hs  = s_axi_awvalid && s_axi_awready;
  wire w_hs   = s_axi_wvalid && s_axi_wready;
  wire wr_go  = aw_got && w_got;
  wire [7:0]  wa = aw_addr;
  wire wr_cmd = wr_go && (wa == REG_CMD);
  wire wr_known = (wa == REG_CMD) || (wa == REG_CTRL) || (wa == REG_LIMIT) || (wa == REG_OPERAND)
               || (wa == REG_IRQ_STAT) || (wa == REG_IRQ_MASK);
  // strobes are only valid beside wvalid, so the full-word test is kept with the data
  logic wr_full;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      wr_full <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (aw_hs) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        wr_full <= (s_axi_wstrb == 4'hf);
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- issue sequencer ----------------
  wire fes_op_t cmd_op = fes_op_t'(cmd[CMD_OP_LSB +: 4]);
  wire needs_wait = (cmd_op == ENVIRONMENT_LOAD_OP) || (cmd_op == FULL_STATE_RESTORE_OP);
  wire seg_over   = (operand > limit) && (cmd_op != LEGACY_SET_PROTECTED_OP);
  wire fault_now  = (state == IDLE) && pending && seg_over;
  wire issue_now  = (state == ISSUE) && !link.busy;
  wire done_now   = (issue_now && !needs_wait) || ((state == SYNC_WAIT) && !link.busy);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE:      if (pending && !seg_over) state <= ISSUE;
        ISSUE:     if (issue_now) state <= needs_wait ? SETTLE : IDLE;
        SETTLE:    state <= SYNC_WAIT;
        SYNC_WAIT: if (!link.busy) state <= IDLE;
        default:   state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pending   <= 1'b0;
      cmd       <= 32'h0000_0000;
      fault_vec <= 8'h00;
    end else begin
      if (wr_cmd && wr_full && !pending) begin
        pending <= 1'b1;
        cmd     <= w_data;
      end else if (fault_now || issue_now) begin
        pending <= 1'b0;
      end
      if (fault_now) fault_vec <= VEC_SEGMENT_OVERRUN;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl    <= CTRL_RESET;
      limit   <= LIMIT_RESET;
      operand <= 32'h0000_0000;
      irq_mask <= 3'h0;
    end else if (wr_go && wr_full) begin
      if (wa == REG_CTRL) ctrl <= w_data;
      if (wa == REG_LIMIT) limit <= w_data;
      if (wa == REG_OPERAND) operand <= w_data;
      if (wa == REG_IRQ_MASK) irq_mask <= w_data[2:0];
    end
  end

  // ---------------- interrupts: set wins over write-one-clear ----------------
  wire [2:0] irq_set = {fault_now, link.exc_pending && !exc_d, done_now};
  wire [2:0] irq_clr = (wr_go && wr_full && (wa == REG_IRQ_STAT)) ? w_data[2:0] : 3'h0;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_stat <= 3'h0;
      exc_d    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      exc_d    <= link.exc_pending;
    end
  end
  assign irq_out = |(irq_stat & irq_mask);

  // ---------------- read channel ----------------
  wire [31:0] dev_stat = {22'h000000, pending, link.exc_pending, link.busy, link.status};
  wire        rd_known = (s_axi_araddr <= REG_FAULT) && (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux =
      (s_axi_araddr == REG_CMD)      ? cmd :
      (s_axi_araddr == REG_CTRL)     ? ctrl :
      (s_axi_araddr == REG_LIMIT)    ? limit :
      (s_axi_araddr == REG_OPERAND)  ? operand :
      (s_axi_araddr == REG_DEV_STAT) ? dev_stat :
      (s_axi_araddr == REG_IRQ_STAT) ? {29'h0, irq_stat} :
      (s_axi_araddr == REG_IRQ_MASK) ? {29'h0, irq_mask} :
      (s_axi_araddr == REG_FAULT)    ? {24'h0, fault_vec} : 32'h0000_0000;

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- link drive ----------------
  // escapes go out only while the coprocessor is idle, so no explicit wait is needed
  assign link.esc_valid = issue_now;
  assign link.op        = cmd_op;
  assign link.cls       = fes_cls_t'(cmd[CMD_CLS_LSB +: 3]);
  assign link.sign      = cmd[CMD_SIGN];
  assign link.res_ovf   = cmd[CMD_OVF];
  assign link.res_unf   = cmd[CMD_UNF];
  assign link.rnd       = ctrl[CTRL_RND_LSB +: 2];
  assign link.mask      = ctrl[CTRL_MASK_LSB +: (SW_WIDTH-1)];
  assign link.prot_mode = ctrl[CTRL_PROT];
  // is kept by SETTLE/SYNC_WAIT: done is held back until busy falls again
endmodule
`default_nettype wire

//--- verilog/fes_link_if.sv
// link between the host controller and the coprocessor exception unit
`timescale 1ns/1ps
`default_nettype none
interface fes_link_if;
  import fes_pkg::*;
  logic                esc_valid;
  fes_op_t             op;
  fes_cls_t            cls;
  logic                sign;
  logic                res_ovf;
  logic                res_unf;
  logic [1:0]          rnd;
  logic [SW_WIDTH-2:0] mask;
  logic                prot_mode;
  logic                busy;
  logic [SW_WIDTH-1:0] status;
  logic                exc_pending;

  modport dev (input esc_valid, op, cls, sign, res_ovf, res_unf, rnd, mask, prot_mode,
               output busy, status, exc_pending);
  modport host (output esc_valid, op, cls, sign, res_ovf, res_unf, rnd, mask, prot_mode,
                input busy, status, exc_pending);
endinterface
`default_nettype wire

//--- verilog/fes_pkg.sv
// shared constants and types for the coprocessor exception unit and its host controller
package fes_pkg;

  // escape instruction classes seen by the exception unit
  typedef enum logic [3:0] {
    ARITH_OP,
    SQUARE_ROOT_OP,
    DIVIDE_OP,
    PARTIAL_REMAINDER_OP,
    STORE_INTEGER_OP,
    STORE_PACKED_DECIMAL_POP_OP,
    TRANSCENDENTAL_OP,
    EXPONENT_SIGNIFICAND_EXTRACT_OP,
    STACK_LOAD_EXT_OP,
    STACK_LOAD_SD_OP,
    COMPARE_OP,
    ENVIRONMENT_LOAD_OP,
    FULL_STATE_RESTORE_OP,
    LEGACY_SET_PROTECTED_OP,
    FULL_STATE_SAVE_OP,
    ENVIRONMENT_STORE_OP
  } fes_op_t;

  // operand class as decoded upstream
  typedef enum logic [2:0] {
    CLS_NORMAL,
    CLS_ZERO,
    CLS_DENORMAL,
    CLS_QUIET_NAN,
    CLS_SIGNALING_NAN,
    CLS_STACK_UNDER,
    CLS_STACK_OVER,
    CLS_INFINITY
  } fes_cls_t;

  // kind of value delivered to the destination
  typedef enum logic [2:0] {
    RES_NONE,
    RES_NUMBER,
    RES_QUIET_NAN,
    RES_INFINITY,
    RES_MAX_FINITE,
    RES_ZERO,
    RES_MIN_DENORMAL
  } fes_res_t;

  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_DOWN    = 2'h1;
  localparam logic [1:0] RND_UP      = 2'h2;
  localparam logic [1:0] RND_ZERO    = 2'h3;

  // status word and exception mask share this layout
  localparam int SW_WIDTH     = 7;
  localparam int SW_INVALID   = 0;
  localparam int SW_DENORMAL  = 1;
  localparam int SW_ZERO_DIV  = 2;
  localparam int SW_OVERFLOW  = 3;
  localparam int SW_UNDERFLOW = 4;
  localparam int SW_PRECISION = 5;
  localparam int SW_STACK     = 6;
  localparam logic [SW_WIDTH-1:0] SW_RESET = 7'h00;

  localparam int BUSY_CYCLES = 4;

  // register map of the host controller
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_CTRL     = 8'h04;
  localparam logic [7:0] REG_LIMIT    = 8'h08;
  localparam logic [7:0] REG_OPERAND  = 8'h0c;
  localparam logic [7:0] REG_DEV_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_FAULT    = 8'h1c;

  // command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_CLS_LSB = 4;
  localparam int CMD_SIGN    = 7;
  localparam int CMD_OVF     = 8;
  localparam int CMD_UNF     = 9;
  // control word fields
  localparam int CTRL_RND_LSB  = 0;
  localparam int CTRL_MASK_LSB = 2;
  localparam int CTRL_PROT     = 9;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_01fc;
  localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;

  localparam int IRQ_DONE  = 0;
  localparam int IRQ_EXC   = 1;
  localparam int IRQ_FAULT = 2;

  localparam logic [7:0] VEC_SEGMENT_OVERRUN = 8'h0d;
endpackage

//--- verilog/fes_sat_round.sv
// value delivered on a masked overflow or underflow, per rounding mode
`timescale 1ns/1ps
`default_nettype none
module fes_sat_round
  import fes_pkg::*;
(
  input  wire logic [1:0] rnd_in,
  input  wire logic       sign_in,
  input  wire logic       ovf_in,
  output fes_pkg::fes_res_t res_out
);
  // the direction of rounding decides whether we move away from zero
  wire away_pos = (rnd_in == RND_UP) && !sign_in;
  wire away_neg = (rnd_in == RND_DOWN) && sign_in;
  wire to_inf   = (rnd_in == RND_NEAREST) || away_pos || away_neg;
  wire to_tiny  = away_pos || away_neg;

  assign res_out = ovf_in ? (to_inf ? RES_INFINITY : RES_MAX_FINITE)
                          : (to_tiny ? RES_MIN_DENORMAL : RES_ZERO);
endmodule
`default_nettype wire
